// file: fpwc_pkg.sv
/*
  constants, state encoding and address helpers shared by the flash
  program/write controller. assumes a 50 MHz system clock and a core that
  issues at most one move request per cycle.
*/
package fpwc_pkg;

  // register offsets on the plain register port
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_FLEN      = 8'h01;
  localparam logic [7:0]  REG_STAT      = 8'h02;
  localparam logic [7:0]  REG_BANK      = 8'h03;

  // field positions
  localparam int          CTRL_REDIRECT = 0;
  localparam int          CTRL_ERASE    = 1;
  localparam int          CTRL_SCRATCH  = 2;
  localparam int          FLEN_BIT      = 0;
  localparam int          STAT_BUSY     = 0;
  localparam int          BANK_LSB      = 4;
  localparam logic [1:0]  BANK_RESET    = 2'h1;

  // timing, typical figures
  localparam int          CLK_MHZ       = 50;
  localparam int          WRITE_US      = 50;
  localparam int          ERASE_MS      = 12;
  localparam int          TMR_W         = 20;
  localparam logic [TMR_W-1:0] WRITE_CYCLES = TMR_W'(WRITE_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] ERASE_CYCLES = TMR_W'(ERASE_MS * 1000 * CLK_MHZ);

  // array geometry
  localparam logic [17:0] PAGE_MASK     = 18'h3fc00;
  localparam logic [17:0] SCR_PAGE_MASK = 18'h3ff80;
  localparam logic [17:0] SCRATCH_BASE  = 18'h20000;
  localparam logic [15:0] SCRATCH_TOP   = 16'h00ff;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CODE = 4'h2,
    ST_OLD  = 4'h4,
    ST_WAIT = 4'h8
  } fpwc_state_e;

  // core address to array address: scratch page, bank window or bank 0
  function automatic logic [17:0] map_addr(input logic [15:0] a, input logic [1:0] bank, input logic scr);
    if (scr && (a <= SCRATCH_TOP)) begin
      map_addr = SCRATCH_BASE | {10'h000, a[7:0]};
    end else if (a[15]) begin
      map_addr = {1'b0, bank, a[14:0]};
    end else begin
      map_addr = {3'h0, a[14:0]};
    end
  endfunction : map_addr

  // first byte of the erase page holding an array address
  function automatic logic [17:0] page_base(input logic [17:0] p);
    page_base = (p >= SCRATCH_BASE) ? (p & SCR_PAGE_MASK) : (p & PAGE_MASK);
  endfunction : page_base

endpackage : fpwc_pkg

// file: fpwc_cycle_timer.sv
/*
  down counter that times one flash write or erase cycle.
  assumes start is a one-cycle pulse given only while idle.
*/
`timescale 1ns/100ps
`default_nettype none
module fpwc_cycle_timer (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // control
  input  wire logic                    start,
  input  wire logic [fpwc_pkg::TMR_W-1:0] load,
  // completion
  output logic                         done
);

  typedef struct packed {
    logic [fpwc_pkg::TMR_W-1:0] cnt;
    logic                       run;
    logic                       done;
  } fpwc_tmr_s;

  fpwc_tmr_s r;
  fpwc_tmr_s next_r;

  // done pulses in the cycle the last count expires
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    if (start) begin
      next_r.cnt = load;
      next_r.run = 1'b1;
    end else if (r.run) begin
      if (r.cnt <= fpwc_pkg::TMR_W'(1)) begin
        next_r.run  = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.cnt = r.cnt - fpwc_pkg::TMR_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;

endmodule : fpwc_cycle_timer
`default_nettype wire

// file: fpwc_irq_hold.sv
/*
  interrupt gate used during flash operations. assumes irq_req bits are
  one-cycle request pulses and bit 0 has the highest priority.
*/
`timescale 1ns/100ps
`default_nettype none
module fpwc_irq_hold (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // core state
  input  wire logic       busy,
  input  wire logic       exec_cached,
  input  wire logic       halted,
  // requests
  input  wire logic [7:0] irq_req,
  input  wire logic [7:0] irq_cached,
  // service grant; one-hot when idle, but while busy every newly arriving cached request is granted at once when exec_cached is set and halted is clear
  output logic [7:0]      irq_take
);

  typedef struct packed {
    logic [7:0] pend;
    logic [7:0] take;
  } fpwc_irq_s;

  fpwc_irq_s r;
  fpwc_irq_s next_r;
  logic [7:0] all;

  // a request landing on the bit being granted is merged into that grant, not kept pending
  always_comb begin
    next_r = r;
    all    = r.pend | irq_req;
    if (busy) begin
      next_r.take = irq_req & irq_cached & {8{exec_cached & ~halted}};
      next_r.pend = r.pend | (irq_req & ~next_r.take);
    end else begin
      next_r.take = all & 8'(~all + 8'h01);
      next_r.pend = (r.pend & ~next_r.take) | (irq_req & ~next_r.take);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign irq_take = r.take;

endmodule : fpwc_irq_hold
`default_nettype wire

// file: fpwc_flash_ctrl.sv
/*
  flash program/write controller: register port, move routing, byte
  program, page erase, fetch stall and interrupt hold.
  assumes a flash array answering a read in the same cycle as arr_rd, that
  takes a byte on arr_wr and erases the page at arr_addr on arr_erase.
*/
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fpwc_flash_ctrl #(
  parameter logic [fpwc_pkg::TMR_W-1:0] ERASE_CYCLES = fpwc_pkg::ERASE_CYCLES,
  parameter logic                       LARGE_MEM    = 1'b1
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // xdata moves from the core
  input  wire logic        xw_valid,
  input  wire logic [15:0] xw_addr,
  input  wire logic [7:0]  xw_data,
  input  wire logic        xr_valid,
  input  wire logic [15:0] xr_addr,
  // external RAM side
  output logic             xram_we,
  output logic             xram_re,
  output logic [15:0]      xram_addr,
  output logic [7:0]       xram_wdata,
  // code reads from the core (fetch misses and code moves)
  input  wire logic        code_rd,
  input  wire logic        code_is_move,
  input  wire logic [15:0] code_addr,
  output logic [7:0]       code_rdata,
  output logic             code_rvalid,
  output logic             core_stall,
  // test port programming
  input  wire logic        jtag_wr,
  input  wire logic        jtag_erase,
  input  wire logic [17:0] jtag_addr,
  input  wire logic [7:0]  jtag_data,
  // interrupts
  input  wire logic [7:0]  irq_req,
  input  wire logic [7:0]  irq_cached,
  input  wire logic        exec_cached,
  output logic [7:0]       irq_take,
  // status
  output logic             flash_busy_flag,
  // flash array
  output logic             arr_rd,
  output logic             arr_wr,
  output logic             arr_erase,
  output logic [17:0]      arr_addr,
  output logic [7:0]       arr_wdata,
  input  wire logic [7:0]  arr_rdata
);

  typedef struct packed {
    fpwc_pkg::fpwc_state_e st;
    logic                  flash_write_redirect;
    logic                  erase_redirect_enable;
    logic                  scratch_select;
    logic                  software_flash_enable;
    logic [1:0]            code_bank_select;
    logic                  busy;
    logic [17:0]           op_addr;
    logic [7:0]            op_data;
    logic                  code_pend;
    logic [17:0]           code_paddr;
    logic [7:0]            code_rdata;
    logic                  code_rvalid;
    logic                  xram_we;
    logic                  xram_re;
    logic [15:0]           xram_addr;
    logic [7:0]            xram_wdata;
    logic                  arr_rd;
    logic                  arr_wr;
    logic                  arr_erase;
    logic [17:0]           arr_addr;
    logic [7:0]            arr_wdata;
    logic                  tmr_start;
    logic [fpwc_pkg::TMR_W-1:0] tmr_load;
    logic [7:0]            reg_rdata;
  } fpwc_ctrl_s;

  fpwc_ctrl_s r;
  fpwc_ctrl_s next_r;

  logic        tmr_done;
  logic [1:0]  eff_bank;
  logic [17:0] sw_paddr;
  logic [17:0] cd_paddr;
  logic        sw_write;
  logic        sw_erase;
  logic        jt_any;
  logic        start_op;

  // small part has no upper banks to pick; the window always shows bank 1
  assign eff_bank = LARGE_MEM ? r.code_bank_select : fpwc_pkg::BANK_RESET;

  // array addresses for the pending software write and the code read
  assign sw_paddr = fpwc_pkg::map_addr(xw_addr, eff_bank, r.scratch_select);
  assign cd_paddr = fpwc_pkg::map_addr(code_addr, eff_bank, r.scratch_select & code_is_move);

  // software write or erase only through a redirected, enabled xdata move
  assign sw_write = xw_valid & r.flash_write_redirect & r.software_flash_enable
                    & ~r.erase_redirect_enable;
  assign sw_erase = xw_valid & r.flash_write_redirect & r.software_flash_enable
                    & r.erase_redirect_enable;
  assign jt_any   = jtag_wr | jtag_erase;
  // new operations start only from idle; a busy array drops them
  assign start_op = (r.st == fpwc_pkg::ST_IDLE) & ~r.busy & (jt_any | sw_write | sw_erase);

  fpwc_cycle_timer u_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (r.tmr_start),
    .load    (r.tmr_load),
    .done    (tmr_done)
  );

  fpwc_irq_hold u_irq (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .busy        (r.busy),
    .exec_cached (exec_cached),
    .halted      (r.code_pend),
    .irq_req     (irq_req),
    .irq_cached  (irq_cached),
    .irq_take    (irq_take)
  );

  // register port, move routing and the operation sequencer
  always_comb begin
    next_r             = r;
    next_r.reg_rdata   = 8'h00;
    next_r.xram_we     = 1'b0;
    next_r.xram_re     = 1'b0;
    next_r.arr_rd      = 1'b0;
    next_r.arr_wr      = 1'b0;
    next_r.arr_erase   = 1'b0;
    next_r.tmr_start   = 1'b0;
    next_r.code_rvalid = 1'b0;

    // register writes; hardware itself never drops the redirect bit
    if (reg_wr) begin
      case (reg_addr)
        fpwc_pkg::REG_CTRL: begin
          next_r.flash_write_redirect  = reg_wdata[fpwc_pkg::CTRL_REDIRECT];
          next_r.erase_redirect_enable = reg_wdata[fpwc_pkg::CTRL_ERASE];
          next_r.scratch_select        = reg_wdata[fpwc_pkg::CTRL_SCRATCH];
        end
        fpwc_pkg::REG_FLEN: begin
          next_r.software_flash_enable = reg_wdata[fpwc_pkg::FLEN_BIT];
        end
        fpwc_pkg::REG_BANK: begin
          next_r.code_bank_select = reg_wdata[fpwc_pkg::BANK_LSB+1:fpwc_pkg::BANK_LSB];
        end
        default: begin
        end
      endcase
    end

    // register reads answer one cycle later; unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        fpwc_pkg::REG_CTRL: begin
          next_r.reg_rdata[fpwc_pkg::CTRL_REDIRECT] = r.flash_write_redirect;
          next_r.reg_rdata[fpwc_pkg::CTRL_ERASE]    = r.erase_redirect_enable;
          next_r.reg_rdata[fpwc_pkg::CTRL_SCRATCH]  = r.scratch_select;
        end
        fpwc_pkg::REG_FLEN: begin
          next_r.reg_rdata[fpwc_pkg::FLEN_BIT] = r.software_flash_enable;
        end
        fpwc_pkg::REG_STAT: begin
          next_r.reg_rdata[fpwc_pkg::STAT_BUSY] = r.busy;
        end
        fpwc_pkg::REG_BANK: begin
          next_r.reg_rdata[fpwc_pkg::BANK_LSB+1:fpwc_pkg::BANK_LSB] = r.code_bank_select;
        end
        default: begin
        end
      endcase
    end

    // xdata reads never look at flash, whatever the redirect bit says
    if (xr_valid) begin
      next_r.xram_re   = 1'b1;
      next_r.xram_addr = xr_addr;
    end

    // unredirected writes keep their default target
    if (xw_valid && !r.flash_write_redirect) begin
      next_r.xram_we    = 1'b1;
      next_r.xram_addr  = xw_addr;
      next_r.xram_wdata = xw_data;
    end

    // a code read that cannot reach the array now waits and stalls the core
    if (code_rd && !((r.st == fpwc_pkg::ST_IDLE) && !r.busy && !start_op && !r.code_pend)) begin
      next_r.code_pend  = 1'b1;
      next_r.code_paddr = cd_paddr;
    end

    case (r.st)
      fpwc_pkg::ST_IDLE: begin
        if (start_op) begin
          // test port wins over software when both ask at once
          next_r.busy = 1'b1;
          if (jt_any) begin
            next_r.op_addr = jtag_addr;
            next_r.op_data = jtag_data;
          end else begin
            next_r.op_addr = sw_paddr;
            next_r.op_data = xw_data;
          end
          if (jtag_erase || (!jtag_wr && sw_erase)) begin
            next_r.arr_erase = 1'b1;
            next_r.arr_addr  = fpwc_pkg::page_base(jtag_erase ? jtag_addr : sw_paddr);
            next_r.tmr_start = 1'b1;
            next_r.tmr_load  = ERASE_CYCLES;
            next_r.st        = fpwc_pkg::ST_WAIT;
          end else begin
            // fetch the old byte first so programming can only clear bits
            next_r.arr_rd   = 1'b1;
            next_r.arr_addr = jtag_wr ? jtag_addr : sw_paddr;
            next_r.st       = fpwc_pkg::ST_OLD;
          end
        end else if (r.code_pend || code_rd) begin
          // code moves are the only software path that reads flash
          next_r.arr_rd    = 1'b1;
          next_r.arr_addr  = r.code_pend ? r.code_paddr : cd_paddr;
          next_r.code_pend = 1'b0;
          next_r.st        = fpwc_pkg::ST_CODE;
        end
      end
      fpwc_pkg::ST_CODE: begin
        next_r.code_rdata  = arr_rdata;
        next_r.code_rvalid = 1'b1;
        next_r.st          = fpwc_pkg::ST_IDLE;
      end
      fpwc_pkg::ST_OLD: begin
        next_r.arr_wr    = 1'b1;
        next_r.arr_addr  = r.op_addr;
        next_r.arr_wdata = arr_rdata & r.op_data;
        next_r.tmr_start = 1'b1;
        next_r.tmr_load  = fpwc_pkg::WRITE_CYCLES;
        next_r.st        = fpwc_pkg::ST_WAIT;
      end
      fpwc_pkg::ST_WAIT: begin
        // busy drops with the timer; a held fetch goes out from idle next
        if (tmr_done) begin
          next_r.busy = 1'b0;
          next_r.st   = fpwc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_r.st   = fpwc_pkg::ST_IDLE;
        next_r.busy = 1'b0;
      end
    endcase
  end

  // one register bank for all control state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r                  <= '0;
      r.st               <= fpwc_pkg::ST_IDLE;
      r.code_bank_select <= fpwc_pkg::BANK_RESET;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign reg_rdata       = r.reg_rdata;
  assign xram_we         = r.xram_we;
  assign xram_re         = r.xram_re;
  assign xram_addr       = r.xram_addr;
  assign xram_wdata      = r.xram_wdata;
  assign code_rdata      = r.code_rdata;
  assign code_rvalid     = r.code_rvalid;
  assign core_stall      = r.code_pend;
  assign flash_busy_flag = r.busy;
  assign arr_rd          = r.arr_rd;
  assign arr_wr          = r.arr_wr;
  assign arr_erase       = r.arr_erase;
  assign arr_addr        = r.arr_addr;
  assign arr_wdata       = r.arr_wdata;

endmodule : fpwc_flash_ctrl
`default_nettype wire

// file: fpwc_props.sv
/*
  assertions for the flash program/write controller.
  assumes binding to fpwc_flash_ctrl, one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module fpwc_props #(
  parameter logic [fpwc_pkg::TMR_W-1:0] ERASE_CYCLES = fpwc_pkg::ERASE_CYCLES,
  parameter logic                       LARGE_MEM    = 1'b1
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // core side
  input wire logic        xw_valid,
  input wire logic [15:0] xw_addr,
  input wire logic [7:0]  xw_data,
  input wire logic        xr_valid,
  input wire logic [15:0] xr_addr,
  input wire logic        code_rd,
  input wire logic        code_rvalid,
  input wire logic        core_stall,
  input wire logic        jtag_wr,
  input wire logic [17:0] jtag_addr,
  // external ram
  input wire logic        xram_we,
  input wire logic        xram_re,
  input wire logic [15:0] xram_addr,
  input wire logic [7:0]  xram_wdata,
  // interrupts and status
  input wire logic [7:0]  irq_req,
  input wire logic [7:0]  irq_cached,
  input wire logic        exec_cached,
  input wire logic [7:0]  irq_take,
  input wire logic        flash_busy_flag,
  // array
  input wire logic        arr_rd,
  input wire logic        arr_wr,
  input wire logic        arr_erase,
  input wire logic [17:0] arr_addr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // a program is a read of the old byte then the merged write
  sequence s_prog;
    arr_rd ##1 arr_wr;
  endsequence

  a_ram_read: assert property (xr_valid && !xw_valid |=> xram_re && xram_addr == $past(xr_addr))
    else $error("xdata read not routed to ram");
  a_ram_write: assert property (xram_we |-> $past(xw_valid) && xram_addr == $past(xw_addr)
    && xram_wdata == $past(xw_data))
    else $error("ram write fields wrong");
  a_prog_steps: assert property ($rose(flash_busy_flag) && !arr_erase |-> s_prog)
    else $error("program not read then write");
  a_busy_holds: assert property ($rose(flash_busy_flag) |-> flash_busy_flag [*8])
    else $error("busy dropped early");
  a_no_start: assert property ($past(flash_busy_flag) && flash_busy_flag |-> !arr_rd && !arr_erase)
    else $error("array started while busy");
  a_stall_busy: assert property (code_rd && flash_busy_flag |=> core_stall)
    else $error("fetch not stalled while busy");
  a_stall_free: assert property ($fell(flash_busy_flag) && core_stall |-> ##[1:4] code_rvalid)
    else $error("stalled fetch not released");
  a_irq_hold: assert property (flash_busy_flag && !exec_cached |=> irq_take == 8'h00)
    else $error("interrupt served while held");
  a_irq_cached: assert property (flash_busy_flag && exec_cached && !core_stall
    |=> irq_take == $past(irq_req & irq_cached))
    else $error("cached interrupt not served");
  a_jtag_start: assert property (jtag_wr && !flash_busy_flag && !core_stall && !code_rd
    && !$past(code_rd) |=> arr_rd && arr_addr == $past(jtag_addr))
    else $error("test port write not started");
  a_erase_page: assert property (arr_erase |-> flash_busy_flag
    && (arr_addr[17] ? arr_addr[6:0] == 7'h00 : arr_addr[9:0] == 10'h000))
    else $error("erase address not page base");
endmodule : fpwc_props

bind fpwc_flash_ctrl fpwc_props #(.ERASE_CYCLES(ERASE_CYCLES), .LARGE_MEM(LARGE_MEM)) fpwc_props_inst (
  .sys_clk, .rst_n, .xw_valid, .xw_addr, .xw_data, .xr_valid, .xr_addr, .code_rd, .code_rvalid,
  .core_stall, .jtag_wr, .jtag_addr, .xram_we, .xram_re, .xram_addr, .xram_wdata, .irq_req,
  .irq_cached, .exec_cached, .irq_take, .flash_busy_flag, .arr_rd, .arr_wr, .arr_erase, .arr_addr
);
`default_nettype wire

// file: fpwc_array_model.sv
/*
  behavioural flash array on the far side of the controller.
  assumes the read answer stands while the registered arr_rd is up, which is
  when the controller merges it; only 1024 bytes kept.
*/
`timescale 1ns/100ps
`default_nettype none
module fpwc_array_model (
  // clock
  input wire logic        sys_clk,
  // array port
  input wire logic        arr_rd,
  input wire logic        arr_wr,
  input wire logic        arr_erase,
  input wire logic [17:0] arr_addr,
  input wire logic [7:0]  arr_wdata,
  output logic [7:0]      arr_rdata
);
  logic [7:0] mem [0:1023];
  logic [7:0] last;

  // blank part starts erased
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 8'hff;
    last = 8'h00;
  end

  // cells only discharge on write; erase wipes the whole kept page
  always @(posedge sys_clk) begin
    if (arr_rd) last <= mem[arr_addr[9:0]];
    if (arr_wr) mem[arr_addr[9:0]] <= mem[arr_addr[9:0]] & arr_wdata;
    if (arr_erase) for (int i = 0; i < 1024; i++) mem[i] <= 8'hff;
  end

  // the controller samples the old byte in the arr_rd cycle itself;
  // outside it the bus shows no stale byte
  assign arr_rdata = arr_rd ? mem[arr_addr[9:0]] : ~last;
endmodule : fpwc_array_model
`default_nettype wire

// file: test_flash_program_write_control.sv
/*
  self-checking bench for the flash program/write controller.
  assumes the array model as far side and a shortened erase count.
*/
`timescale 1ns/100ps
`default_nettype none
module test_flash_program_write_control;
  logic        sys_clk = 1'b0, rst_n = 1'b0, rd_d = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d1, d2;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, xw_valid = 1'b0, xr_valid = 1'b0, xram_we, xram_re;
  logic [15:0] xw_addr = 16'h0000, xr_addr = 16'h0000, code_addr = 16'h0000, xram_addr;
  logic [7:0]  xw_data = 8'h00, jtag_data = 8'h00, xram_wdata, code_rdata;
  logic        code_rd = 1'b0, code_is_move = 1'b0, code_rvalid, core_stall;
  logic        jtag_wr = 1'b0, jtag_erase = 1'b0, exec_cached = 1'b0, flash_busy_flag;
  logic [17:0] jtag_addr = 18'h00000, arr_addr;
  logic [7:0]  irq_req = 8'h00, irq_cached = 8'h00, irq_take, arr_wdata, arr_rdata;
  logic        arr_rd, arr_wr, arr_erase;
  logic [7:0]  qr[$], qc[$], qi[$];
  logic [25:0] qa[$], qx[$];
  int          n_fail = 0, tests_run = 0, cnt;

  fpwc_flash_ctrl #(.ERASE_CYCLES(20'h00032), .LARGE_MEM(1'b1)) fpwc_flash_ctrl_inst (
    .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .xw_valid, .xw_addr,
    .xw_data, .xr_valid, .xr_addr, .xram_we, .xram_re, .xram_addr, .xram_wdata, .code_rd,
    .code_is_move, .code_addr, .code_rdata, .code_rvalid, .core_stall, .jtag_wr, .jtag_erase,
    .jtag_addr, .jtag_data, .irq_req, .irq_cached, .exec_cached, .irq_take, .flash_busy_flag,
    .arr_rd, .arr_wr, .arr_erase, .arr_addr, .arr_wdata, .arr_rdata);
  fpwc_array_model fpwc_array_model_inst (
    .sys_clk, .arr_rd, .arr_wr, .arr_erase, .arr_addr, .arr_wdata, .arr_rdata);

  // 50 MHz clock
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  task results;
    $display("counts: %0d compared, %0d failed", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_byte

  task cmp_word(input logic [25:0] got, input logic [25:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word

  // register port cycles, one strobe cycle each
  task reg_w(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : reg_w

  task reg_r(input logic [7:0] a, input logic [7:0] e);
    qr.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : reg_r

  // core requests: write=0 read=1 code=2 jtag=3 irq=4
  task req(input int k, input logic [17:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    case (k)
      0: begin xw_valid <= 1'b1; xw_addr <= a[15:0]; xw_data <= d; end
      1: begin xr_valid <= 1'b1; xr_addr <= a[15:0]; end
      2: begin code_rd <= 1'b1; code_is_move <= 1'b1; code_addr <= a[15:0]; qc.push_back(d); end
      3: begin jtag_wr <= 1'b1; jtag_addr <= a; jtag_data <= d; end
      default: irq_req <= d;
    endcase
    @(posedge sys_clk);
    {xw_valid, xr_valid, code_rd, jtag_wr} <= 4'h0;
    irq_req <= 8'h00;
  endtask : req

  // bounded wait; cnt ends one above the busy length
  task wait_idle;
    cnt = 0;
    do begin
      @(negedge sys_clk);
      cnt++;
    end while (flash_busy_flag !== 1'b0 && cnt < 6000);
    if (cnt >= 6000) begin
      n_fail++;
      $display("MISMATCH t=%0t busy %h exp %h", $time, flash_busy_flag, 1'b0);
      results();
    end
  endtask : wait_idle

  // result watcher; an empty queue forces a mismatch on surprise output
  always @(posedge sys_clk) rd_d <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_d) cmp_byte(reg_rdata, qr.size() ? qr.pop_front() : ~reg_rdata);
    if (code_rvalid) cmp_byte(code_rdata, qc.size() ? qc.pop_front() : ~code_rdata);
    if (irq_take != 8'h00) cmp_byte(irq_take, qi.size() ? qi.pop_front() : ~irq_take);
    if (arr_wr || arr_erase) cmp_word({arr_addr, arr_erase ? 8'h00 : arr_wdata},
      qa.size() ? qa.pop_front() : 26'h3ffffff);
    if (xram_we || xram_re) cmp_word({xram_we, xram_re, xram_addr, xram_we ? xram_wdata : 8'h00},
      qx.size() ? qx.pop_front() : 26'h3ffffff);
  end

  initial begin
    void'($urandom(42036));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values, read-only status, unmapped place
    reg_r(fpwc_pkg::REG_CTRL, 8'h00);
    reg_r(fpwc_pkg::REG_BANK, 8'h10);
    reg_w(fpwc_pkg::REG_STAT, 8'hff);
    reg_r(fpwc_pkg::REG_STAT, 8'h00);
    reg_r(8'h7e, 8'h00);
    $display("test 1 done: register map");
    // xdata routing with redirect clear, then redirect set without enable
    d1 = 8'($urandom);
    qx.push_back({2'h2, 16'h1234, d1});
    req(0, 18'h01234, d1);
    qx.push_back({2'h1, 16'h4321, 8'h00});
    req(1, 18'h04321, 8'h00);
    reg_w(fpwc_pkg::REG_CTRL, 8'h01);
    req(0, 18'h00010, d1);
    qx.push_back({2'h1, 16'h0040, 8'h00});
    req(1, 18'h00040, 8'h00);
    $display("test 2 done: xdata routing");
    // test port programs with software enable off
    qa.push_back({18'h00005, 8'h5a});
    req(3, 18'h00005, 8'h5a);
    wait_idle();
    $display("test 3 done: test port write");
    // banked write, ignored repeat, interrupts and stalled fetch
    reg_w(fpwc_pkg::REG_BANK, 8'h30);
    reg_w(fpwc_pkg::REG_FLEN, 8'h01);
    d1 = 8'($urandom);
    qa.push_back({18'h18123, d1});
    req(0, 18'h08123, d1);
    req(0, 18'h08124, 8'h00);
    exec_cached <= 1'b1;
    irq_cached <= 8'h20;
    qi.push_back(8'h20);
    req(4, 18'h00000, 8'h20);
    exec_cached <= 1'b0;
    qi.push_back(8'h08);
    req(4, 18'h00000, 8'h08);
    req(2, 18'h08123, d1);
    @(negedge sys_clk);
    cmp_byte({7'h00, core_stall}, 8'h01);
    wait_idle();
    cmp_byte((cnt + 9 > 2500 && cnt + 9 < 2506) ? 8'h01 : 8'h00, 8'h01);
    repeat (4) @(posedge sys_clk);
    reg_r(fpwc_pkg::REG_CTRL, 8'h01);
    $display("test 4 done: program and stall");
    // reprogram only clears bits
    d2 = 8'($urandom);
    qa.push_back({18'h18123, d1 & d2});
    req(0, 18'h08123, d2);
    wait_idle();
    $display("test 5 done: reprogram");
    // page erase, then ram routing restored
    reg_w(fpwc_pkg::REG_CTRL, 8'h03);
    qa.push_back({18'h18000, 8'h00});
    req(0, 18'h08155, 8'h00);
    wait_idle();
    cmp_byte((cnt > 50 && cnt < 55) ? 8'h01 : 8'h00, 8'h01);
    reg_w(fpwc_pkg::REG_CTRL, 8'h07);
    qa.push_back({18'h20080, 8'h00});
    req(0, 18'h00085, 8'h00);
    wait_idle();
    reg_w(fpwc_pkg::REG_CTRL, 8'h01);
    req(2, 18'h08123, 8'hff);
    qa.push_back({18'h18123, d2});
    req(0, 18'h08123, d2);
    wait_idle();
    reg_w(fpwc_pkg::REG_CTRL, 8'h00);
    reg_w(fpwc_pkg::REG_BANK, 8'h10);
    qx.push_back({2'h2, 16'h0077, d2});
    req(0, 18'h00077, d2);
    repeat (6) @(posedge sys_clk);
    cmp_byte(8'(qr.size() + qc.size() + qi.size() + qa.size() + qx.size()), 8'h00);
    $display("test 6 done: erase");
    results();
  end
endmodule : test_flash_program_write_control
`default_nettype wire
